/* File: hdl/bbf_defs.svh */
// Constants for the boot-block flash host controller.
// Assumes a 10 MHz clk_i and a 1M x 16 flash on the pin side.
`ifndef BBF_DEFS_SVH
`define BBF_DEFS_SVH

// Clock and pin timing, times in ns
`define BBF_CLK_NS       100
`define BBF_ACCESS_NS    90
`define BBF_WE_PULSE_NS  70
`define BBF_ACC_CYC      (3'((`BBF_ACCESS_NS + `BBF_CLK_NS - 1) / `BBF_CLK_NS))
`define BBF_WE_CYC       (3'((`BBF_WE_PULSE_NS + `BBF_CLK_NS - 1) / `BBF_CLK_NS))

// Register word indices, wb byte address bits [5:2]
`define BBF_REG_CTRL     4'h0
`define BBF_REG_ADDR     4'h1
`define BBF_REG_WDATA    4'h2
`define BBF_REG_STATUS   4'h3
`define BBF_REG_RDATA    4'h4

// Control register fields
`define BBF_CTRL_GO      0
`define BBF_CTRL_OP_LO   1
`define BBF_CTRL_OP_HI   2
`define BBF_CTRL_PD      4
`define BBF_CTRL_UNLOCK  5
`define BBF_CTRL_TOP     6

// Status register fields
`define BBF_ST_BUSY      0
`define BBF_ST_DONE      1
`define BBF_ST_ERR       2
`define BBF_ST_BLK_LO    8
`define BBF_ST_BLK_HI    13
`define BBF_ST_DEV_LO    16
`define BBF_ST_DEV_HI    23

// Flash command codes and device status bits
`define BBF_CMD_ERASE    8'h20
`define BBF_CMD_CONFIRM  8'hD0
`define BBF_CMD_PROGRAM  8'h40
`define BBF_CMD_RD_ARRAY 8'hFF
`define BBF_SR_READY     7
`define BBF_SR_ERR_MASK  8'h3A

// Block layout: 32K-word main blocks, 4K-word parameter blocks
`define BBF_MAIN_TOP     5'h1F
`define BBF_MAIN_BOT     5'h00
`define BBF_TOP_PARAM0   6'h1F
`define BBF_BOT_MAIN0    6'h07

// Reset values
`define BBF_CTRL_RST     32'h0000_0000
`define BBF_ZERO16       16'h0000
`define BBF_ZERO20       20'h0_0000
`endif

/* File: hdl/bbf_pkg.sv */
// Types shared by the boot-block flash host controller.
// Assumes the constants of bbf_defs.svh.
`default_nettype none
package bbf_pkg;
    typedef enum logic [1:0] {
        OP_READ    = 2'h0,
        OP_CMD     = 2'h1,
        OP_PROGRAM = 2'h2,
        OP_ERASE   = 2'h3
    } bbf_op_t;

    typedef enum logic [3:0] {
        PC_IDLE   = 4'h1,
        PC_SETUP  = 4'h2,
        PC_STROBE = 4'h4,
        PC_HOLD   = 4'h8
    } bbf_pc_t;

    typedef enum logic [4:0] {
        SQ_IDLE   = 5'h01,
        SQ_ISSUE  = 5'h02,
        SQ_WAIT   = 5'h04,
        SQ_CHECK  = 5'h08,
        SQ_FINISH = 5'h10
    } bbf_sq_t;
endpackage
`default_nettype wire

/* File: hdl/bbf_pin_cycle.sv */
// One flash bus cycle, read or write, on the asynchronous pins.
// Assumes data_bus_i is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "bbf_defs.svh"
module bbf_pin_cycle import bbf_pkg::*; (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic        write_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [15:0] data_bus_i,
    output logic             done_o,
    output logic [15:0]      rdata_o,
    output logic [19:0]      word_address_o,
    output logic [15:0]      data_bus_o,
    output logic             data_bus_oe_o,
    output logic             chip_select_n_o,
    output logic             output_enable_n_o,
    output logic             write_enable_n_o
);
    bbf_pc_t    st;
    logic       wr;
    logic [2:0] cnt;
    logic [2:0] len;

    assign len = wr ? `BBF_WE_CYC : `BBF_ACC_CYC;

    // Phase sequencer: setup, strobe, hold, release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st                <= PC_IDLE;
            wr                <= 1'b0;
            cnt               <= 3'h0;
            done_o            <= 1'b0;
            word_address_o    <= `BBF_ZERO20;
            data_bus_o        <= `BBF_ZERO16;
            data_bus_oe_o     <= 1'b0;
            chip_select_n_o   <= 1'b1;
            output_enable_n_o <= 1'b1;
            write_enable_n_o  <= 1'b1;
        end else begin
            done_o <= 1'b0;
            case (st)
                PC_IDLE: begin
                    if (start_i) begin
                        st              <= PC_SETUP;
                        wr              <= write_i;
                        word_address_o  <= addr_i;
                        data_bus_o      <= wdata_i;
                        data_bus_oe_o   <= write_i;
                        chip_select_n_o <= 1'b0;
                    end
                end
                PC_SETUP: begin
                    st                <= PC_STROBE;
                    cnt               <= 3'h0;
                    write_enable_n_o  <= ~wr;
                    output_enable_n_o <= wr;
                end
                PC_STROBE: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == len - 3'h1) begin
                        st                <= PC_HOLD;
                        write_enable_n_o  <= 1'b1;
                        output_enable_n_o <= 1'b1;
                    end
                end
                PC_HOLD: begin
                    // Data held one cycle past the rising strobe
                    st              <= PC_IDLE;
                    data_bus_oe_o   <= 1'b0;
                    chip_select_n_o <= 1'b1;
                    done_o          <= 1'b1;
                end
                default: st <= PC_IDLE;
            endcase
        end
    end

    // Read data taken at the end of the output-enable strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= `BBF_ZERO16;
        end else if (st == PC_STROBE && !wr && cnt == len - 3'h1) begin
            rdata_o <= data_bus_i;
        end
    end

    a_strobe_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(~write_enable_n_o && ~output_enable_n_o))
        else $error("write and output strobes low together");
    a_strobe_in_cs: assert property (@(posedge clk_i) disable iff (rst_i)
        (~write_enable_n_o || ~output_enable_n_o) |-> ~chip_select_n_o)
        else $error("strobe low while chip select high");
    a_we_width: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(write_enable_n_o) |-> data_bus_oe_o ##1 (write_enable_n_o && data_bus_oe_o))
        else $error("write strobe width or data hold wrong");
    a_no_read_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        data_bus_oe_o |-> output_enable_n_o && ~chip_select_n_o)
        else $error("host drives the data bus during a read");
endmodule
`default_nettype wire

/* File: hdl/bbf_host.sv */
// Wishbone-controlled host for a 1M x 16 boot-block flash on its pins.
// Assumes a classic Wishbone master and a flash with no clock of its own.
`timescale 1ns/1ps
`default_nettype none
`include "bbf_defs.svh"
// Overview of operation
// - Write strobe low marks a write cycle
// - Host holds reset high outside power-down and outside its own rst_i reset
// - Protect input high unlocks soft-protected blocks
// - Data bus carries reads, writes, commands
// - Only complete command sequences start operations
// - Setup code precedes confirm or data
// - Read-array command follows program or erase
module bbf_host import bbf_pkg::*; (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [19:0]      word_address_o,
    input  wire logic [15:0] data_bus_i,
    output logic [15:0]      data_bus_o,
    output logic             data_bus_oe_o,
    output logic             chip_select_n_o,
    output logic             output_enable_n_o,
    output logic             write_enable_n_o,
    output logic             reset_powerdown_n_o,
    output logic             write_protect_o
);
    // Byte-lane merge for register writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Block number of a word address for either boot placement
    function automatic logic [5:0] block_of(input logic [19:0] a, input logic top);
        logic [5:0] r;
        r = 6'h00;
        if (top) begin
            if (a[19:15] == `BBF_MAIN_TOP) begin
                r = `BBF_TOP_PARAM0 + {3'h0, a[14:12]};
            end else begin
                r = {1'b0, a[19:15]};
            end
        end else begin
            if (a[19:15] == `BBF_MAIN_BOT) begin
                r = {3'h0, a[14:12]};
            end else begin
                r = `BBF_BOT_MAIN0 + {1'b0, a[19:15]};
            end
        end
        return r;
    endfunction

    logic [31:0] ctrl;
    logic [19:0] flash_addr;
    logic [15:0] prog_data;
    logic        done_flag;
    logic        err_flag;
    logic [7:0]  dev_status;
    logic [15:0] read_data;
    logic [3:0]  reg_idx;
    logic        wb_req;
    logic        wb_wr;
    bbf_sq_t     sq;
    bbf_op_t     op;
    logic [1:0]  step;
    logic        busy;
    logic        cur_wr;
    logic        cur_poll;
    logic        cur_last;
    logic [15:0] cur_data;
    logic        pc_start;
    logic        pc_done;
    logic [15:0] pc_rdata;
    logic [7:0]  last_cmd;

    assign reg_idx = wb_adr_i[5:2];
    assign wb_req  = wb_cyc_i && wb_stb_i;
    assign wb_wr   = wb_req && wb_we_i && wb_ack_o;
    assign busy    = (sq != SQ_IDLE);

    // Wishbone answer one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            wb_dat_o <= 32'h0000_0000;   // Unmapped words read zero
            case (reg_idx)
                `BBF_REG_CTRL:  wb_dat_o <= {ctrl[31:1], 1'b0};
                `BBF_REG_ADDR:  wb_dat_o <= {12'h000, flash_addr};
                `BBF_REG_WDATA: wb_dat_o <= {16'h0000, prog_data};
                `BBF_REG_STATUS: begin
                    wb_dat_o[`BBF_ST_BUSY]                  <= busy;
                    wb_dat_o[`BBF_ST_DONE]                  <= done_flag;
                    wb_dat_o[`BBF_ST_ERR]                   <= err_flag;
                    wb_dat_o[`BBF_ST_BLK_HI:`BBF_ST_BLK_LO] <=
                        block_of(flash_addr, ctrl[`BBF_CTRL_TOP]);
                    wb_dat_o[`BBF_ST_DEV_HI:`BBF_ST_DEV_LO] <= dev_status;
                end
                `BBF_REG_RDATA: wb_dat_o <= {16'h0000, read_data};
                default:        wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Control, address and data registers; locked while an operation runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl       <= `BBF_CTRL_RST;
            flash_addr <= `BBF_ZERO20;
            prog_data  <= `BBF_ZERO16;
        end else begin
            ctrl[`BBF_CTRL_GO] <= 1'b0;
            if (wb_wr && !busy) begin
                case (reg_idx)
                    `BBF_REG_CTRL:  ctrl <= lane_merge(ctrl, wb_dat_i, wb_sel_i);
                    `BBF_REG_ADDR:  flash_addr <= 20'(lane_merge({12'h000, flash_addr},
                                                           wb_dat_i, wb_sel_i));
                    `BBF_REG_WDATA: prog_data <= 16'(lane_merge({16'h0000, prog_data},
                                                          wb_dat_i, wb_sel_i));
                    default: ;
                endcase
            end
        end
    end

    // Reset and protect pins follow control bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_powerdown_n_o <= 1'b0;
            write_protect_o     <= 1'b0;
        end else begin
            reset_powerdown_n_o <= ~ctrl[`BBF_CTRL_PD];
            write_protect_o     <= ctrl[`BBF_CTRL_UNLOCK];
        end
    end

    // Step table: setup code, then confirm or data, poll, read array
    always_comb begin
        cur_wr   = 1'b1;
        cur_poll = 1'b0;
        cur_last = 1'b0;
        cur_data = prog_data;
        case (op)
            OP_READ: begin
                cur_wr   = 1'b0;
                cur_last = 1'b1;
            end
            OP_CMD: cur_last = 1'b1;
            OP_PROGRAM, OP_ERASE: begin
                case (step)
                    2'h0: cur_data = {8'h00, (op == OP_ERASE) ? `BBF_CMD_ERASE
                                                              : `BBF_CMD_PROGRAM};
                    2'h1: cur_data = (op == OP_ERASE) ? {8'h00, `BBF_CMD_CONFIRM}
                                                      : prog_data;
                    2'h2: begin
                        cur_wr   = 1'b0;    // Device answers reads with status
                        cur_poll = 1'b1;
                    end
                    default: begin
                        cur_data = {8'h00, `BBF_CMD_RD_ARRAY};
                        cur_last = 1'b1;
                    end
                endcase
            end
            default: cur_last = 1'b1;
        endcase
    end

    assign pc_start = (sq == SQ_ISSUE);

    // Operation sequencer; a go is refused while busy or powered down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sq   <= SQ_IDLE;
            op   <= OP_READ;
            step <= 2'h0;
        end else begin
            case (sq)
                SQ_IDLE: begin
                    if (ctrl[`BBF_CTRL_GO] && !ctrl[`BBF_CTRL_PD]) begin
                        sq   <= SQ_ISSUE;
                        op   <= bbf_op_t'(ctrl[`BBF_CTRL_OP_HI:`BBF_CTRL_OP_LO]);
                        step <= 2'h0;
                    end
                end
                SQ_ISSUE: sq <= SQ_WAIT;
                SQ_WAIT: begin
                    if (pc_done) begin
                        if (cur_poll) begin
                            sq <= SQ_CHECK;
                        end else if (cur_last) begin
                            sq <= SQ_FINISH;
                        end else begin
                            sq   <= SQ_ISSUE;
                            step <= step + 2'h1;
                        end
                    end
                end
                SQ_CHECK: begin
                    // No time limit: a stuck device keeps the host busy
                    sq <= SQ_ISSUE;
                    if (pc_rdata[`BBF_SR_READY]) begin
                        step <= step + 2'h1;
                    end
                end
                SQ_FINISH: sq <= SQ_IDLE;
                default:   sq <= SQ_IDLE;
            endcase
        end
    end

    // Results; done is sticky and a finish beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_flag  <= 1'b0;
            err_flag   <= 1'b0;
            dev_status <= 8'h00;
            read_data  <= `BBF_ZERO16;
        end else begin
            if (sq == SQ_FINISH) begin
                done_flag <= 1'b1;
            end else if (wb_wr && reg_idx == `BBF_REG_STATUS
                         && wb_sel_i[0] && wb_dat_i[`BBF_ST_DONE]) begin
                done_flag <= 1'b0;
            end
            if (sq == SQ_CHECK && pc_rdata[`BBF_SR_READY]) begin
                dev_status <= pc_rdata[7:0];
                err_flag   <= |(pc_rdata[7:0] & `BBF_SR_ERR_MASK);
            end else if (sq == SQ_IDLE && ctrl[`BBF_CTRL_GO]) begin
                err_flag   <= 1'b0;
            end
            if (sq == SQ_WAIT && pc_done && !cur_wr && !cur_poll) begin
                read_data <= pc_rdata;
            end
        end
    end

    // Low byte of the last bus write, command or program data, kept for checking command order
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_cmd <= 8'h00;
        end else if (pc_start && cur_wr) begin
            last_cmd <= cur_data[7:0];
        end
    end

    bbf_pin_cycle u_pin (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .start_i           (pc_start),
        .write_i           (cur_wr),
        .addr_i            (flash_addr),
        .wdata_i           (cur_data),
        .data_bus_i        (data_bus_i),
        .done_o            (pc_done),
        .rdata_o           (pc_rdata),
        .word_address_o    (word_address_o),
        .data_bus_o        (data_bus_o),
        .data_bus_oe_o     (data_bus_oe_o),
        .chip_select_n_o   (chip_select_n_o),
        .output_enable_n_o (output_enable_n_o),
        .write_enable_n_o  (write_enable_n_o)
    );

    a_pd_quiet_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        !reset_powerdown_n_o |-> chip_select_n_o && !data_bus_oe_o)
        else $error("pins active during power-down");
    a_reset_held_high: assert property (@(posedge clk_i) disable iff (rst_i)
        busy |-> reset_powerdown_n_o)
        else $error("reset pin low during an operation");
    a_protect_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ctrl[`BBF_CTRL_UNLOCK]) |=> write_protect_o)
        else $error("protect pin did not follow unlock bit");
    a_erase_order: assert property (@(posedge clk_i) disable iff (rst_i)
        (pc_start && cur_wr && op == OP_ERASE && step == 2'h1)
            |-> last_cmd == `BBF_CMD_ERASE && cur_data[7:0] == `BBF_CMD_CONFIRM)
        else $error("erase confirm without erase setup");
    a_read_array_end: assert property (@(posedge clk_i) disable iff (rst_i)
        (sq == SQ_FINISH && (op == OP_PROGRAM || op == OP_ERASE))
            |-> last_cmd == `BBF_CMD_RD_ARRAY)
        else $error("operation ended without read-array command");
    a_ready_gates: assert property (@(posedge clk_i) disable iff (rst_i)
        (sq == SQ_CHECK && !pc_rdata[`BBF_SR_READY]) |=> sq == SQ_ISSUE && $stable(step))
        else $error("poll advanced before ready flag");
    a_cycle_bounded: assert property (@(posedge clk_i) disable iff (rst_i)
        pc_start |-> ##[3:8] pc_done)
        else $error("pin cycle did not complete in time");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule
`default_nettype wire

/* File: testbench/bbf_flash_model.sv */
// Behavioural 1M x 16 boot-block flash on the host's pins.
// Assumes the bench resolves the shared data bus from the host's output enable alone.
`timescale 1ns/1ps
`default_nettype none
module bbf_flash_model (
    input  wire logic        top_i,
    input  wire logic        cs_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        rp_n_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [15:0] din_i,
    input  wire logic [31:0] busy_reads_i,
    output logic [15:0]      dout_o
);
    logic [15:0] mem [int];
    logic [15:0] q = 16'h0000;
    int          mode = 0;
    int          busy = 0;

    // Same erase block, small blocks only in the parameter region
    function automatic bit same(logic [19:0] x, logic [19:0] y);
        bit prm;
        prm = top_i ? (x[19:15] == 5'h1F) : (x[19:15] == 5'h00);
        return x[19:15] == y[19:15] && (!prm || x[14:12] == y[14:12]);
    endfunction

    // Commands and data latch on the write strobe's rising edge
    always @(posedge we_n_i) begin
        if (rp_n_i === 1'b1 && cs_n_i === 1'b0) begin
            if (mode == 2) begin
                mem[addr_i] = din_i;
                busy = busy_reads_i;
                mode = 1;
            end else if (mode == 3) begin
                if (din_i[7:0] == 8'hD0) begin
                    foreach (mem[k]) if (same(k[19:0], addr_i)) mem[k] = 16'hFFFF;
                    busy = busy_reads_i;
                end
                mode = 1;
            end else begin
                case (din_i[7:0])
                    8'h40, 8'h10: mode = 2;
                    8'h20:        mode = 3;
                    8'h70:        mode = 1;
                    8'hFF:        mode = 0;
                    default:      ;
                endcase
            end
        end
    end

    // Reset low returns to array read and clears the sequencer
    always @(negedge rp_n_i) begin
        mode = 0;
        busy = 0;
    end

    // Read data fetched as output enable falls; status counts down when slow
    always @(negedge oe_n_i) begin
        if (cs_n_i === 1'b0 && rp_n_i === 1'b1) begin
            if (mode == 1) begin
                q = {8'h00, (busy == 0) ? 8'h80 : 8'h00};
                if (busy > 0) busy--;
            end else begin
                q = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
            end
        end
    end

    // Released bus shows the inverse so a stale value never passes
    assign dout_o = (!cs_n_i && !oe_n_i && rp_n_i) ? q : ~q;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the flash host, over classic Wishbone.
// Assumes the flash model beside it and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] RC = 8'h00, RA = 8'h04, RW = 8'h08, RS = 8'h0C, RR = 8'h10;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, top = 0;
    logic        hoe, cs_n, oe_n, we_n, rp_n, wp;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, q, wbo;
    logic [19:0] fa, a;
    logic [19:0] bnd [6] = '{20'hF8000, 20'hF7FFF, 20'h07FFF, 20'h08000, 20'hFFFFF, 20'h00000};
    logic [15:0] hq, fq, bus, d;
    logic [15:0] ref_m [int];
    int          errors = 0, checks = 0, seed = 92, busy_reads = 0, i, n;

    always #50 clk_i = ~clk_i;
    assign bus = hoe ? hq : fq;

    bbf_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wbo), .wb_ack_o(ack),
        .word_address_o(fa), .data_bus_i(bus), .data_bus_o(hq), .data_bus_oe_o(hoe),
        .chip_select_n_o(cs_n), .output_enable_n_o(oe_n), .write_enable_n_o(we_n),
        .reset_powerdown_n_o(rp_n), .write_protect_o(wp));
    bbf_flash_model flash_u (.top_i(top), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .rp_n_i(rp_n), .addr_i(fa), .din_i(bus), .busy_reads_i(busy_reads), .dout_o(fq));

    // Single comparison path for every result
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we  <= w;
        adr <= ad;
        dat <= dt;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = wbo;
        cyc <= 0;
        stb <= 0;
    endtask

    // Start an operation and poll until the sequencer is idle
    task automatic run(input logic [1:0] op);
        wb(1, RC, {25'h0, top, 3'h0, op, 1'b1});
        n = 0;
        do begin
            wb(0, RS, 0);
            n++;
        end while (q[0] !== 1'b0 && n < 1000);
        chk("status_flags", 32'h2, {29'h0, q[2:0]});
    endtask

    // Block index expected from the boot placement
    function automatic int bidx(logic t, logic [19:0] x);
        if (t) return (x[19:15] == 5'h1F) ? 31 + x[14:12] : x[19:15];
        return (x[19:15] == 5'h00) ? x[14:12] : x[19:15] + 7;
    endfunction

    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        chk("rp_in_reset", 0, rp_n);
        chk("cs_in_reset", 1, cs_n);
        chk("oe_in_reset", 0, hoe);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
        chk("rp_running", 1, rp_n);
        wb(0, RC, 0);
        chk("ctrl_reset", 0, q);
        wb(0, 8'h3C, 0);
        chk("unmapped", 0, q);
        $display("test reset done");
        for (i = 0; i < 10; i++) begin
            a = (i < 6) ? bnd[i] : 20'($random(seed));
            d = 16'($random(seed));
            top = i[0];
            busy_reads = i;
            ref_m[a] = d;
            wb(1, RA, {12'h0, a});
            wb(1, RW, {16'h0, d});
            run(2'd2);
            chk("dev_status", 8'h80, q[23:16]);
            chk("block_index", bidx(top, a), q[13:8]);
            run(2'd0);
            wb(0, RR, 0);
            chk("read_back", {16'h0, d}, q);
        end
        $display("test program done");
        for (i = 0; i < 2; i++) begin
            top = !i[0];
            a = bnd[i * 2];
            wb(1, RA, {12'h0, a});
            run(2'd3);
            foreach (ref_m[k]) if (bidx(top, k[19:0]) == bidx(top, a)) ref_m[k] = 16'hFFFF;
        end
        foreach (ref_m[k]) begin
            wb(1, RA, k);
            run(2'd0);
            wb(0, RR, 0);
            chk("after_erase", {16'h0, ref_m[k]}, q);
        end
        $display("test erase done");
        wb(1, RW, 32'h70);
        run(2'd1);
        run(2'd0);
        wb(0, RR, 0);
        chk("raw_command", 32'h80, q);
        wb(1, RW, 32'hFF);
        run(2'd1);
        wb(1, RS, 32'h2);
        wb(0, RS, 0);
        chk("done_clear", 0, q[1]);
        $display("test command done");
        wb(1, RC, 32'h30);
        wb(1, RC, 32'h31);
        wb(0, RS, 0);
        chk("pd_busy", 0, q[0]);
        chk("pd_pin", 0, rp_n);
        chk("unlock_pin", 1, wp);
        chk("pd_cs", 1, cs_n);
        wb(1, RC, 0);
        $display("test powerdown done");
        close_out();
    end

    // Watchdog against a stuck sequencer or missing ack
    initial begin
        repeat (30000) @(posedge clk_i);
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
